/* tscc_pkg.sv */
// tscc_pkg: constants and types for the temperature sensor configuration control
// assumes a 40 MHz system clock and a synchronous active-high reset
package tscc_pkg;
	// configuration register bit positions
	localparam int CFG_SHUTDOWN_BIT = 0;
	localparam int CFG_INTMODE_BIT = 1;
	localparam int CFG_POLARITY_BIT = 2;
	localparam int CFG_QUEUE_LO_BIT = 3;
	localparam int CFG_QUEUE_HI_BIT = 4;
	localparam int CFG_FORMAT_BIT = 5;
	localparam int CFG_TIMEOUT_BIT = 6;
	localparam int CFG_SINGLE_BIT = 7;
	// power-up values
	localparam logic [7:0] CFG_RESET_NOPIN = 8'h00;
	localparam logic [7:0] CFG_RESET_PIN = 8'h40;
	localparam logic [15:0] TEMP_RESET = 16'h0000;
	localparam logic [15:0] HYST_RESET = 16'h4B00;
	localparam logic [15:0] UPPER_RESET = 16'h5000;
	// extended format offset: 64 degrees in 1/256 degree steps
	localparam logic [16:0] EXT_OFFSET = 17'h04000;
	localparam logic [16:0] NORM_MAX = 17'h07FFF;
	localparam logic [16:0] NORM_MIN = 17'h18000;
	// fault counts per queue code
	localparam logic [2:0] FAULTS_Q0 = 3'h1;
	localparam logic [2:0] FAULTS_Q1 = 3'h2;
	localparam logic [2:0] FAULTS_Q2 = 3'h4;
	localparam logic [2:0] FAULTS_Q3 = 3'h6;
	// bus timeout
	localparam int CLK_HZ = 40000000;
	localparam int TIMEOUT_MS = 50;
	localparam int TIMEOUT_CYCLES = CLK_HZ / 1000 * TIMEOUT_MS;
	localparam int TO_W = 22;

	typedef enum logic [1:0] {
		TSCC_IDLE = 2'b00,
		TSCC_CONV = 2'b01,
		TSCC_SHDN = 2'b11
	} tscc_state_t;

	// register write port
	typedef struct packed {
		logic cfg_we;
		logic hyst_we;
		logic upper_we;
		logic [15:0] data;
	} tscc_wr_t;

	// result from the converter, in true 1/256 degree units, signed 17 bits
	typedef struct packed {
		logic done;
		logic [16:0] value;
	} tscc_conv_t;
endpackage

/* tscc_fmt.sv */
// tscc_fmt: maps a true temperature to its stored 16-bit encoding
// assumes a signed 17-bit value in 1/256 degree steps
`timescale 1ns/100ps
module tscc_fmt
(
	input wire logic [16:0] true_value,
	input wire logic extended,
	output logic [15:0] coded
);
	import tscc_pkg::*;
	logic [16:0] shifted;

	always_comb
	begin
		shifted = extended ? true_value - EXT_OFFSET : true_value;
		// clamp to the 16-bit two's complement range
		if (!shifted[16] && shifted > NORM_MAX)
			coded = NORM_MAX[15:0];
		else if (shifted[16] && shifted < NORM_MIN)
			coded = NORM_MIN[15:0];
		else
			coded = shifted[15:0];
	end
endmodule // tscc_fmt

/* tscc_ctrl.sv */
// tscc_ctrl: configuration register, data format, fault queue, over-temp output,
// shutdown and single conversion, bus timeout
// assumes the serial front end decodes register writes/reads and the converter
// reports each finished conversion with a one-cycle done pulse
`timescale 1ns/100ps
module tscc_ctrl
#(
	parameter bit HAS_RESET_PIN = 1'b0,
	parameter int TIMEOUT_CNT = tscc_pkg::TIMEOUT_CYCLES
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic reset_pin_n,
	input wire logic sda_in,
	input wire tscc_pkg::tscc_wr_t wr,
	input wire logic reg_read,
	input wire tscc_pkg::tscc_conv_t conv,
	output logic [7:0] cfg_rd,
	output logic [15:0] temp_rd,
	output logic [15:0] hyst_rd,
	output logic [15:0] upper_rd,
	output logic conv_start,
	output logic shutdown_active,
	output logic serial_reset,
	output logic overtemp_output_o,
	output logic overtemp_output_oe
);
	import tscc_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// input synchronisers and combined reset
	logic [1:0] rpin_sync_reg;
	logic [1:0] sda_sync_reg;
	logic rpin_n;
	logic sda_s;
	logic srst;

	always_ff @(posedge clk)
	begin
		rpin_sync_reg <= {rpin_sync_reg[0], reset_pin_n};
		sda_sync_reg <= {sda_sync_reg[0], sda_in};
	end

	assign rpin_n = rpin_sync_reg[1];
	assign sda_s = sda_sync_reg[1];
	assign srst = rst || (HAS_RESET_PIN && !rpin_n);

	////////////////////////////////////////////////////////////////////////////
	// configuration register
	logic [7:0] cfg_reg;
	logic [7:0] cfg_reset;
	tscc_state_t state_reg;
	logic in_shdn;
	logic conv_done_single;

	assign cfg_reset = HAS_RESET_PIN ? CFG_RESET_PIN : CFG_RESET_NOPIN;
	assign in_shdn = (state_reg == TSCC_SHDN);
	assign conv_done_single = conv.done && cfg_reg[CFG_SINGLE_BIT];

	always_ff @(posedge clk)
	begin
		if (srst)
			cfg_reg <= cfg_reset;
		else if (wr.cfg_we)
		begin
			cfg_reg[6:0] <= wr.data[6:0];
			// only honoured from shutdown, and not while a single shot runs
			if (wr.data[CFG_SINGLE_BIT] && in_shdn)
				cfg_reg[CFG_SINGLE_BIT] <= 1'b1;
			else if (conv_done_single)
				cfg_reg[CFG_SINGLE_BIT] <= 1'b0;
		end
		else if (conv_done_single)
			cfg_reg[CFG_SINGLE_BIT] <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// conversion sequencing
	always_ff @(posedge clk)
	begin
		if (srst)
			state_reg <= TSCC_IDLE;
		else
			case (state_reg)
				TSCC_IDLE:
					state_reg <= TSCC_CONV;
				TSCC_CONV:
					if (conv.done)
						// finish the running conversion before stopping
						state_reg <= (cfg_reg[CFG_SHUTDOWN_BIT] || cfg_reg[CFG_SINGLE_BIT])
							? TSCC_SHDN : TSCC_IDLE;
				TSCC_SHDN:
					if (wr.cfg_we && wr.data[CFG_SINGLE_BIT])
						state_reg <= TSCC_IDLE;
					else if (!cfg_reg[CFG_SHUTDOWN_BIT])
						state_reg <= TSCC_IDLE;
				default:
					state_reg <= TSCC_IDLE;
			endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			conv_start <= 1'b0;
		else
			conv_start <= (state_reg == TSCC_IDLE);
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			shutdown_active <= 1'b0;
		else
			shutdown_active <= in_shdn;
	end

	////////////////////////////////////////////////////////////////////////////
	// data format and stored temperature
	logic fmt_reg;
	logic [15:0] temp_reg;
	logic [15:0] coded;

	tscc_fmt u_fmt
	(
		.true_value(conv.value),
		.extended(fmt_reg),
		.coded(coded)
	);

	// format in use by stored data follows the bit only on a finished conversion
	always_ff @(posedge clk)
	begin
		if (srst)
			fmt_reg <= 1'b0;
		else if (conv.done)
			fmt_reg <= cfg_reg[CFG_FORMAT_BIT];
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			temp_reg <= TEMP_RESET;
		else if (conv.done)
			temp_reg <= coded;
	end

	////////////////////////////////////////////////////////////////////////////
	// threshold registers
	logic [15:0] hyst_reg;
	logic [15:0] upper_reg;

	always_ff @(posedge clk)
	begin
		if (srst)
			hyst_reg <= HYST_RESET;
		else if (wr.hyst_we)
			hyst_reg <= wr.data;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			upper_reg <= UPPER_RESET;
		else if (wr.upper_we)
			upper_reg <= wr.data;
	end

	// thresholds use the same encoding as the new sample
	logic above_upper;
	logic below_hyst;
	assign above_upper = $signed(coded) > $signed(upper_reg);
	assign below_hyst = $signed(coded) < $signed(hyst_reg);

	////////////////////////////////////////////////////////////////////////////
	// fault queue
	logic [2:0] need;
	logic [2:0] hi_cnt_reg;
	logic [2:0] lo_cnt_reg;
	logic [1:0] queue_prev_reg;
	logic queue_chg;

	always_comb
	begin
		case (cfg_reg[CFG_QUEUE_HI_BIT:CFG_QUEUE_LO_BIT])
			2'h0: need = FAULTS_Q0;
			2'h1: need = FAULTS_Q1;
			2'h2: need = FAULTS_Q2;
			2'h3: need = FAULTS_Q3;
			default: need = FAULTS_Q0;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			queue_prev_reg <= 2'h0;
		else
			queue_prev_reg <= cfg_reg[CFG_QUEUE_HI_BIT:CFG_QUEUE_LO_BIT];
	end

	assign queue_chg = queue_prev_reg != cfg_reg[CFG_QUEUE_HI_BIT:CFG_QUEUE_LO_BIT];

	// consecutive counts for over-limit and under-hysteresis results
	always_ff @(posedge clk)
	begin
		if (srst || queue_chg)
			hi_cnt_reg <= 3'h0;
		else if (conv.done)
			hi_cnt_reg <= above_upper ? ((hi_cnt_reg == need) ? need : hi_cnt_reg + 3'h1)
				: 3'h0;
	end

	always_ff @(posedge clk)
	begin
		if (srst || queue_chg)
			lo_cnt_reg <= 3'h0;
		else if (conv.done)
			lo_cnt_reg <= below_hyst ? ((lo_cnt_reg == need) ? need : lo_cnt_reg + 3'h1)
				: 3'h0;
	end

	logic hi_trip;
	logic lo_trip;
	assign hi_trip = conv.done && above_upper && (hi_cnt_reg + 3'h1 >= need);
	assign lo_trip = conv.done && below_hyst && (lo_cnt_reg + 3'h1 >= need);

	////////////////////////////////////////////////////////////////////////////
	// over-temperature output
	logic ot_reg;
	logic arm_low_reg;

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			ot_reg <= 1'b0;
			arm_low_reg <= 1'b0;
		end
		else if (!cfg_reg[CFG_INTMODE_BIT])
		begin
			arm_low_reg <= 1'b0;
			if (hi_trip)
				ot_reg <= 1'b1;
			else if (lo_trip)
				ot_reg <= 1'b0;
		end
		else if (in_shdn)
			ot_reg <= 1'b0;
		else if (!arm_low_reg && hi_trip)
		begin
			ot_reg <= 1'b1;
			arm_low_reg <= 1'b1;
		end
		else if (arm_low_reg && lo_trip)
		begin
			ot_reg <= 1'b1;
			arm_low_reg <= 1'b0;
		end
		else if (reg_read)
			ot_reg <= 1'b0;
	end

	// open drain: drive low whenever the output level is low, asserted or not
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			overtemp_output_o <= 1'b0;
			overtemp_output_oe <= 1'b0;
		end
		else
		begin
			overtemp_output_o <= 1'b0;
			overtemp_output_oe <= (ot_reg != cfg_reg[CFG_POLARITY_BIT]);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// bus timeout
	logic [TO_W-1:0] to_cnt_reg;

	always_ff @(posedge clk)
	begin
		if (srst || sda_s || cfg_reg[CFG_TIMEOUT_BIT])
			to_cnt_reg <= '0;
		else if (to_cnt_reg != TIMEOUT_CNT[TO_W-1:0])
			to_cnt_reg <= to_cnt_reg + 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			serial_reset <= 1'b1;
		else
			serial_reset <= !cfg_reg[CFG_TIMEOUT_BIT]
				&& to_cnt_reg == TIMEOUT_CNT[TO_W-1:0] - 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////
	// read-back
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			cfg_rd <= cfg_reset;
			temp_rd <= TEMP_RESET;
			hyst_rd <= HYST_RESET;
			upper_rd <= UPPER_RESET;
		end
		else
		begin
			cfg_rd <= cfg_reg;
			temp_rd <= temp_reg;
			hyst_rd <= hyst_reg;
			upper_rd <= upper_reg;
		end
	end
endmodule // tscc_ctrl

/* tscc_monitor.sv */
// tscc_monitor: port assertions for tscc_ctrl
// bound to tscc_ctrl; sees its ports only
`timescale 1ns/100ps
module tscc_monitor
#(
	parameter bit HAS_RESET_PIN = 1'b0,
	parameter int TIMEOUT_CNT = 20
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic reset_pin_n,
	input wire logic sda_in,
	input wire tscc_pkg::tscc_wr_t wr,
	input wire tscc_pkg::tscc_conv_t conv,
	input wire logic reg_read,
	input wire logic [7:0] cfg_rd,
	input wire logic [15:0] temp_rd,
	input wire logic [15:0] hyst_rd,
	input wire logic [15:0] upper_rd,
	input wire logic conv_start,
	input wire logic shutdown_active,
	input wire logic serial_reset,
	input wire logic overtemp_output_o,
	input wire logic overtemp_output_oe
);
	import tscc_pkg::*;
	int lo_cnt;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst || !reset_pin_n);
	// cycles the data line has stayed low
	always_ff @(posedge clk)
		lo_cnt <= (rst || sda_in) ? 0 : lo_cnt + 1;
	sequence s_one_shot;
		wr.cfg_we && wr.data[CFG_SINGLE_BIT] && shutdown_active;
	endsequence
	sequence s_one_done;
		conv.done && cfg_rd[CFG_SINGLE_BIT];
	endsequence
	reset_val_a: assert property (disable iff (1'b0) rst [*2] |=>
		cfg_rd == (HAS_RESET_PIN ? CFG_RESET_PIN : CFG_RESET_NOPIN)) else $error("bad cfg reset");
	open_drain_a: assert property (overtemp_output_o == 1'b0)
		else $error("pin driven high");
	ot_pin_cause_a: assert property ($changed(overtemp_output_oe) |->
		$past(conv.done, 2) || $past(conv.done, 3) || $past(wr.cfg_we, 2) || $past(reg_read, 2))
		else $error("overtemp pin changed without cause");
	single_go_a: assert property (s_one_shot |-> ##[1:4] conv_start)
		else $error("no conversion start");
	single_clr_a: assert property (s_one_done |-> ##[1:4]
		(!cfg_rd[CFG_SINGLE_BIT] && shutdown_active)) else $error("single bit stuck");
	timeout_gate_a: assert property ($rose(serial_reset) |->
		!cfg_rd[CFG_TIMEOUT_BIT] && lo_cnt >= TIMEOUT_CNT) else $error("false timeout");
	timeout_fire_a: assert property (!cfg_rd[CFG_TIMEOUT_BIT] && lo_cnt == TIMEOUT_CNT
		|-> ##[1:6] serial_reset) else $error("timeout missed");
	temp_update_a: assert property ($changed(temp_rd) |-> $past(conv.done, 2))
		else $error("temperature changed without conversion");
	cfg_write_a: assert property (wr.cfg_we |-> ##2 cfg_rd[6:0] == $past(wr.data[6:0], 2))
		else $error("cfg write lost");
	hyst_write_a: assert property (wr.hyst_we |-> ##2 hyst_rd == $past(wr.data, 2))
		else $error("hysteresis write lost");
	upper_write_a: assert property (wr.upper_we |-> ##2 upper_rd == $past(wr.data, 2))
		else $error("upper limit write lost");
endmodule // tscc_monitor
bind tscc_ctrl tscc_monitor #(.HAS_RESET_PIN(HAS_RESET_PIN), .TIMEOUT_CNT(TIMEOUT_CNT)) mon_i (
	.clk(clk), .rst(rst), .reset_pin_n(reset_pin_n), .sda_in(sda_in), .wr(wr), .conv(conv),
	.reg_read(reg_read), .overtemp_output_oe(overtemp_output_oe),
	.cfg_rd(cfg_rd), .temp_rd(temp_rd), .hyst_rd(hyst_rd), .upper_rd(upper_rd),
	.conv_start(conv_start), .shutdown_active(shutdown_active), .serial_reset(serial_reset),
	.overtemp_output_o(overtemp_output_o));

/* tscc_conv_model.sv */
// tscc_conv_model: converter answering each conversion request after lat cycles
// assumes lat is at least 1 and value is held by the bench
`timescale 1ns/100ps
module tscc_conv_model
(
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [7:0] lat,
	input wire logic [16:0] value,
	output tscc_pkg::tscc_conv_t conv
);
	import tscc_pkg::*;
	int cnt;
	always_ff @(posedge clk)
	begin
		conv.done <= !rst && cnt == 1;
		// outside the done cycle the value toggles so it is never trusted
		if (rst)
			conv.value <= '0;
		else if (cnt == 1)
			conv.value <= value;
		else
			conv.value <= ~conv.value;
		if (rst)
			cnt <= 0;
		else if (start)
			cnt <= lat;
		else if (cnt > 0)
			cnt <= cnt - 1;
	end
endmodule // tscc_conv_model

/* test_temp_sensor_config_control.sv */
// test_temp_sensor_config_control: self-checking bench for tscc_ctrl
// assumes tscc_conv_model as converter and tscc_monitor bound in
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
$display("mismatch %0t %h %h", $time, (a), (b)); end end
module test_temp_sensor_config_control;
	import tscc_pkg::*;
	logic clk, rst, reset_pin_n, sda_in, reg_read, conv_start, shutdown_active, serial_reset;
	logic ot_o, ot_oe;
	logic [7:0] cfg_rd, lat;
	logic [15:0] temp_rd, hyst_rd, upper_rd;
	logic [16:0] value;
	logic [15:0] expq[$];
	tscc_wr_t wr;
	tscc_conv_t conv;
	int failures, num_checks, starts, srst, cyc, s0, k, n;
	int seed = 32'h4B9C21BA;
	bit fmt, fmt_new;
	localparam int COLD = 32'h1000;
	localparam int HOT = 32'h1A00;
	tscc_ctrl #(.HAS_RESET_PIN(1'b1), .TIMEOUT_CNT(20)) tscc_ctrl_i (.clk(clk), .rst(rst),
		.reset_pin_n(reset_pin_n), .sda_in(sda_in), .wr(wr), .reg_read(reg_read), .conv(conv),
		.cfg_rd(cfg_rd), .temp_rd(temp_rd), .hyst_rd(hyst_rd), .upper_rd(upper_rd),
		.conv_start(conv_start), .shutdown_active(shutdown_active), .serial_reset(serial_reset),
		.overtemp_output_o(ot_o), .overtemp_output_oe(ot_oe));
	tscc_conv_model tscc_conv_model_i (.clk(clk), .rst(rst), .start(conv_start), .lat(lat),
		.value(value), .conv(conv));
	////////////////////////////////
	function automatic logic [15:0] enc(input int t, input bit ext);
		int v;
		v = ext ? t - 16384 : t;
		if (v > 32767)
			v = 32767;
		if (v < -32768)
			v = -32768;
		return v[15:0];
	endfunction
	task automatic wreg(input logic [2:0] we, input logic [15:0] d);
		wr <= {we, d};
		@(negedge clk);
		wr <= '0;
		reg_read <= 1'b1;
		@(negedge clk);
		reg_read <= 1'b0;
		repeat (2) @(negedge clk);
	endtask
	task automatic convert(input int t);
		value <= t[16:0];
		lat <= 8'(40 + {$random(seed)} % 20);
		k = 0;
		do
		begin
			@(negedge clk);
			k++;
		end
		while (conv.done !== 1'b1 && k < 300);
		`CHK(conv.done, 1'b1)
		expq.push_back(enc(t, fmt));
		fmt = fmt_new;
		repeat (3) @(negedge clk);
		`CHK(temp_rd, expq.pop_front())
	endtask
	task automatic sda_low();
		sda_in <= 1'b0;
		repeat (40) @(negedge clk);
		sda_in <= 1'b1;
		repeat (4) @(negedge clk);
	endtask
	task final_report;
		if (failures == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (conv_start === 1'b1)
			starts++;
		if (serial_reset === 1'b1 && !rst)
			srst++;
		if (cyc == 20000)
		begin
			failures++;
			final_report;
		end
	end
	initial
	begin
		rst = 1'b1;
		reset_pin_n = 1'b1;
		sda_in = 1'b1;
		reg_read = 1'b0;
		wr = '0;
		lat = 8'h32;
		value = '0;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		repeat (2) @(negedge clk);
		`CHK(cfg_rd, CFG_RESET_PIN)
		`CHK({hyst_rd, upper_rd, temp_rd}, {HYST_RESET, UPPER_RESET, TEMP_RESET})
		`CHK(ot_oe, 1'b0)
		wreg(3'b010, 16'h1400);
		`CHK(hyst_rd, 16'h1400)
		wreg(3'b001, 16'h1900);
		`CHK(upper_rd, 16'h1900)
		for (int q = 0; q < 4; q++)
		begin
			n = (q == 0) ? 1 : q * 2;
			wreg(3'b100, 16'(64 + q * 8));
			repeat (n) convert(COLD);
			repeat (n - 1) convert(HOT);
			convert(COLD);
			repeat (n - 1) convert(HOT);
			`CHK(ot_oe, 1'b0)
			convert(HOT);
			`CHK(ot_oe, 1'b1)
			repeat (n) convert(COLD);
			`CHK(ot_oe, 1'b0)
		end
		// interrupt mode: latch, clear on read, then re-arm on the other threshold
		wreg(3'b100, 16'h0042);
		convert(HOT);
		`CHK(ot_oe, 1'b1)
		reg_read <= 1'b1;
		@(negedge clk);
		reg_read <= 1'b0;
		repeat (2) @(negedge clk);
		`CHK(ot_oe, 1'b0)
		convert(HOT);
		`CHK(ot_oe, 1'b0)
		convert(COLD);
		`CHK(ot_oe, 1'b1)
		// active-high polarity in comparator mode releases the pin while asserted
		wreg(3'b100, 16'h0044);
		`CHK(ot_oe, 1'b0)
		convert(COLD);
		`CHK(ot_oe, 1'b1)
		wreg(3'b100, 16'h0060);
		fmt_new = 1'b1;
		`CHK(temp_rd, enc(COLD, 1'b0))
		for (int i = 0; i < 16; i++)
		begin
			if (i == 8)
			begin
				wreg(3'b100, 16'h0040);
				fmt_new = 1'b0;
			end
			convert($random(seed) % 40000 + 8000);
		end
		wreg(3'b100, 16'h00C0);
		`CHK(cfg_rd, 8'h40)
		s0 = srst;
		sda_low();
		`CHK(srst, s0)
		wreg(3'b100, 16'h0000);
		sda_low();
		`CHK(srst > s0, 1'b1)
		lat <= 8'h03;
		wreg(3'b100, 16'h0041);
		for (k = 0; k < 300 && shutdown_active !== 1'b1; k++)
			@(negedge clk);
		`CHK(shutdown_active, 1'b1)
		s0 = starts;
		wreg(3'b100, 16'h00C1);
		for (k = 0; k < 300 && cfg_rd[7] !== 1'b0; k++)
			@(negedge clk);
		repeat (2) @(negedge clk);
		`CHK(starts, s0 + 1)
		`CHK({cfg_rd, shutdown_active}, {8'h41, 1'b1})
		lat <= 8'h32;
		reset_pin_n <= 1'b0;
		repeat (6) @(negedge clk);
		reset_pin_n <= 1'b1;
		repeat (3) @(negedge clk);
		`CHK(cfg_rd, CFG_RESET_PIN)
		`CHK({hyst_rd, upper_rd, temp_rd}, {HYST_RESET, UPPER_RESET, TEMP_RESET})
		final_report;
	end
endmodule // test_temp_sensor_config_control
